// ===== src/gpod_map.svh
`ifndef GPOD_MAP_SVH
`define GPOD_MAP_SVH

// Register index offsets; byte address is four times the index
`define GPOD_IDX_P0_DATA    8'h80
`define GPOD_IDX_P1_DATA    8'h90
`define GPOD_IDX_P2_DATA    8'hA0
`define GPOD_IDX_P3_DATA    8'hB0
`define GPOD_IDX_P2_OD      8'hE4
`define GPOD_IDX_P0_DIR     8'hF9
`define GPOD_IDX_P1_DIR     8'hFA
`define GPOD_IDX_P2_DIR     8'hFB
`define GPOD_IDX_P3_DIR     8'hFC

`define GPOD_DIR_RESET      8'h00
`define GPOD_OD_RESET       8'h00
`define GPOD_DATA_RESET     8'hFF
`define GPOD_OD_MASK        8'hDC
`define GPOD_P3_MASK        8'h03
`define GPOD_FULL_MASK      8'hFF
`define GPOD_OD_PORT        2
`define GPOD_ZERO32         32'h0000_0000

`endif

// ===== src/gpod_pkg.sv
package gpod_pkg;
	typedef logic [7:0] gpod_byte_t;
	typedef enum logic [1:0] {
		GPOD_IDLE   = 2'b00,
		GPOD_ACCESS = 2'b01
	} gpod_apb_t;
endpackage : gpod_pkg

// ===== src/gpod_pin.sv
`timescale 1ns/100ps
module gpod_pin (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic dir,
	input  wire logic data,
	input  wire logic od_en,
	output logic      pin_o,
	output logic      pin_oe
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_o  <= 1'b0;
			pin_oe <= 1'b0;
		end else begin
			pin_o  <= od_en ? 1'b0 : data;
			pin_oe <= dir & (~od_en | ~data);
		end
	end
endmodule : gpod_pin

// ===== src/gpod_top.sv
// Function
// - Up to 26 pins, each input or output under software control.
// - Output without open-drain drives both high and low.
// - One direction register per port, one bit per pin.
// - Direction bit 0 is input, 1 is output; readable and writable.
// - Reset clears all direction bits to input.
// - Port-2 pins 7,6,4,3,2 have writable open-drain enable bits.
// - Reset clears every open-drain enable bit.
// - Data register read returns live pin levels.
// - Data write latches at once, drives pin only in output mode.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "gpod_map.svh"
module gpod_top #(
	parameter int NPORTS = 4
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NPORTS*8-1:0]   pin_i,
	output logic      [NPORTS*8-1:0]   pin_o,
	output logic      [NPORTS*8-1:0]   pin_oe
);
	import gpod_pkg::*;

	if (NPORTS < 3 || NPORTS > 4) begin : g_bad_nports
		$error("NPORTS must be 3 or 4");
	end

	////////////////////////////////////////////////////////////////////////
	// Register storage
	gpod_byte_t dir_q  [NPORTS];
	gpod_byte_t data_q [NPORTS];
	gpod_byte_t od_q;
	gpod_apb_t  st_q;

	function automatic logic [9:0] word_idx(input logic [11:0] a);
		return a[11:2];
	endfunction : word_idx

	function automatic gpod_byte_t port_mask(input int p);
		return (p == 3) ? `GPOD_P3_MASK : `GPOD_FULL_MASK;
	endfunction : port_mask

	function automatic logic [9:0] dir_idx(input int p);
		case (p)
			0:       return {2'b00, `GPOD_IDX_P0_DIR};
			1:       return {2'b00, `GPOD_IDX_P1_DIR};
			2:       return {2'b00, `GPOD_IDX_P2_DIR};
			default: return {2'b00, `GPOD_IDX_P3_DIR};
		endcase
	endfunction : dir_idx

	function automatic logic [9:0] data_idx(input int p);
		case (p)
			0:       return {2'b00, `GPOD_IDX_P0_DATA};
			1:       return {2'b00, `GPOD_IDX_P1_DATA};
			2:       return {2'b00, `GPOD_IDX_P2_DATA};
			default: return {2'b00, `GPOD_IDX_P3_DATA};
		endcase
	endfunction : data_idx

	logic       wr_en;
	logic       rd_en;
	logic [9:0] idx;
	assign idx   = word_idx(paddr);
	assign wr_en = psel & penable & pwrite & (st_q == GPOD_ACCESS);
	assign rd_en = psel & penable & ~pwrite & (st_q == GPOD_ACCESS);

	////////////////////////////////////////////////////////////////////////
	// APB handshake: one wait state, answer on second access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= GPOD_IDLE;
		end else begin
			case (st_q)
				GPOD_IDLE:   st_q <= (psel & penable) ? GPOD_ACCESS : GPOD_IDLE;
				GPOD_ACCESS: st_q <= GPOD_IDLE;
				default:     st_q <= GPOD_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & penable & (st_q == GPOD_IDLE) & ~pready;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-port direction, data and pin drivers
	genvar gp, gb;
	generate
		for (gp = 0; gp < NPORTS; gp++) begin : g_port
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dir_q[gp] <= `GPOD_DIR_RESET;
				end else if (wr_en && idx == dir_idx(gp)) begin
					dir_q[gp] <= pwdata[7:0] & port_mask(gp);
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					data_q[gp] <= `GPOD_DATA_RESET & port_mask(gp);
				end else if (wr_en && idx == data_idx(gp)) begin
					data_q[gp] <= pwdata[7:0] & port_mask(gp);
				end
			end

			for (gb = 0; gb < 8; gb++) begin : g_bit
				gpod_pin u_pin (
					.pclk    (pclk),
					.presetn (presetn),
					.dir     (dir_q[gp][gb]),
					.data    (data_q[gp][gb]),
					.od_en   ((gp == `GPOD_OD_PORT) ? od_q[gb] : 1'b0),
					.pin_o   (pin_o[gp*8+gb]),
					.pin_oe  (pin_oe[gp*8+gb])
				);
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Port-2 open-drain select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			od_q <= `GPOD_OD_RESET;
		end else if (wr_en && idx == {2'b00, `GPOD_IDX_P2_OD}) begin
			od_q <= pwdata[7:0] & `GPOD_OD_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux and error answer
	logic [31:0] rd_d;
	logic        hit_d;
	always_comb begin
		rd_d  = `GPOD_ZERO32;
		hit_d = (idx == {2'b00, `GPOD_IDX_P2_OD});
		if (hit_d) rd_d = {24'h000000, od_q};
		for (int p = 0; p < NPORTS; p++) begin
			if (idx == dir_idx(p)) begin
				rd_d  = {24'h000000, dir_q[p]};
				hit_d = 1'b1;
			end
			if (idx == data_idx(p)) begin
				rd_d  = {24'h000000, pin_i[p*8 +: 8] & port_mask(p)};
				hit_d = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= `GPOD_ZERO32;
			pslverr <= 1'b0;
		end else begin
			prdata  <= (psel & penable & ~pwrite & (st_q == GPOD_IDLE)) ? rd_d : `GPOD_ZERO32;
			pslverr <= psel & penable & (st_q == GPOD_IDLE) & ~hit_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	dir_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> dir_q[0] == `GPOD_DIR_RESET)
		else $error("direction not cleared at reset");
	od_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> od_q == `GPOD_OD_RESET)
		else $error("open-drain not cleared at reset");
	od_mask_a: assert property (@(posedge pclk) disable iff (!presetn) (od_q & ~`GPOD_OD_MASK) == `GPOD_OD_RESET)
		else $error("open-drain bit outside allowed pins");
	input_float_a: assert property (@(posedge pclk) disable iff (!presetn)
		!dir_q[0][0] |=> !pin_oe[0])
		else $error("input pin driven");
	push_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
		dir_q[0][1] |=> pin_oe[1] && pin_o[1] == $past(data_q[0][1]))
		else $error("push-pull output wrong");
	od_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dir_q[2][7] && od_q[7] && data_q[2][7]) |=> !pin_oe[23])
		else $error("open-drain high driven");
	od_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(dir_q[2][7] && od_q[7] && !data_q[2][7]) |=> pin_oe[23] && !pin_o[23])
		else $error("open-drain low not driven");
	data_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == {2'b00, `GPOD_IDX_P0_DATA}) |=> data_q[0] == $past(pwdata[7:0]))
		else $error("data write not latched");
	read_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && st_q == GPOD_IDLE && idx == {2'b00, `GPOD_IDX_P1_DATA})
		|=> prdata[7:0] == $past(pin_i[15:8]))
		else $error("read does not show pin level");
	dir_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == {2'b00, `GPOD_IDX_P2_DIR}) |=> dir_q[2] == $past(pwdata[7:0]))
		else $error("direction write not latched");
	od_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && idx == {2'b00, `GPOD_IDX_P2_OD}) |=> od_q == ($past(pwdata[7:0]) & `GPOD_OD_MASK))
		else $error("open-drain write not latched");
	pin_reset_a: assert property (@(posedge pclk) $rose(presetn) |-> pin_oe == '0)
		else $error("pin driven after reset");

	////////////////////////////////////////////////////////////////////////
	// Bus answer checks, then cover points
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) pready |=> !pready)
		else $error("ready held too long");
	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn) pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn) !pready |-> prdata == `GPOD_ZERO32)
		else $error("read data outside answer");
	od_low_c: cover property (@(posedge pclk) pin_oe[23] && od_q[7] && !pin_o[23]);
	bad_index_c: cover property (@(posedge pclk) pslverr);
	dir_write_c: cover property (@(posedge pclk) wr_en && idx == {2'b00, `GPOD_IDX_P2_DIR});
	od_write_c: cover property (@(posedge pclk) wr_en && idx == {2'b00, `GPOD_IDX_P2_OD});
	pin_read_c: cover property (@(posedge pclk) rd_en && idx == {2'b00, `GPOD_IDX_P0_DATA});
endmodule : gpod_top

// ===== dv/gpod_pin_model.sv
`timescale 1ns/100ps
module gpod_pin_model (
	input  wire logic [31:0] pin_o,
	input  wire logic [31:0] pin_oe,
	input  wire logic [31:0] ext,
	output logic      [31:0] pin_i
);
	// Released pins follow the board pattern
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule : gpod_pin_model

// ===== dv/test_gpio_direction_open_drain.sv
`timescale 1ns/100ps
`include "gpod_map.svh"
module test_gpio_direction_open_drain;
	import gpod_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pin_i, pin_o, pin_oe, ext, r;
	gpod_byte_t  lfsr_q, dir, dat, od, m, x, oe;
	int          miscompares = 0;
	int          checks_done = 0;
	int          p;
	gpod_top #(.NPORTS(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
	gpod_pin_model i_pins (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	function automatic gpod_byte_t nxt(gpod_byte_t s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nxt
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task end_sim;
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		#200us;
		miscompares++;
		end_sim();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		ext    = 32'h0000_0000;
		lfsr_q = 8'h58;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (p = 0; p < 4; p++) begin
			apb(1'b0, 8'(`GPOD_IDX_P0_DIR + p), 32'h0);
			cmp(r, 32'h0);
		end
		apb(1'b0, `GPOD_IDX_P2_OD, 32'h0);
		cmp(r, 32'h0);
		cmp(pin_oe, 32'h0);
		apb(1'b1, `GPOD_IDX_P2_OD, 32'hFFFF_FFFF);
		apb(1'b0, `GPOD_IDX_P2_OD, 32'h0);
		cmp(r, 32'h0000_00DC);
		apb(1'b0, 8'h00, 32'h0);
		cmp({31'h0, e}, 32'h1);
		cmp(r, 32'h0);
		for (int i = 0; i < 40; i++) begin
			p = i % 4;
			m = (p == 3) ? `GPOD_P3_MASK : `GPOD_FULL_MASK;
			lfsr_q = nxt(lfsr_q);
			dir    = lfsr_q;
			lfsr_q = nxt(lfsr_q);
			dat    = lfsr_q;
			lfsr_q = nxt(lfsr_q);
			x      = lfsr_q;
			lfsr_q = nxt(lfsr_q);
			od     = (p == 2) ? lfsr_q & `GPOD_OD_MASK : 8'h00;
			if (p == 2)
				apb(1'b1, `GPOD_IDX_P2_OD, {24'h0, od});
			apb(1'b1, 8'(`GPOD_IDX_P0_DIR + p), {24'h0, dir});
			apb(1'b1, 8'(`GPOD_IDX_P0_DATA + 16 * p), {24'h0, dat});
			ext[8*p +: 8] <= x;
			repeat (3) @(posedge pclk);
			oe = dir & ~(od & dat) & m;
			cmp({24'h0, pin_oe[8*p +: 8]}, {24'h0, oe});
			cmp({24'h0, pin_o[8*p +: 8] & oe}, {24'h0, dat & ~od & oe});
			apb(1'b0, 8'(`GPOD_IDX_P0_DIR + p), 32'h0);
			cmp(r, {24'h0, dir & m});
			apb(1'b0, 8'(`GPOD_IDX_P0_DATA + 16 * p), 32'h0);
			cmp(r, {24'h0, ((oe & dat & ~od) | (~oe & x)) & m});
		end
		// Second reset in mid-run with registers loaded
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp(pin_oe, 32'h0);
		presetn <= 1'b1;
		apb(1'b0, `GPOD_IDX_P2_DIR, 32'h0);
		cmp(r, 32'h0);
		apb(1'b0, `GPOD_IDX_P2_OD, 32'h0);
		cmp(r, 32'h0);
		apb(1'b1, `GPOD_IDX_P0_DATA, 32'hA5);
		repeat (3) @(posedge pclk);
		cmp(pin_oe, 32'h0);
		apb(1'b1, `GPOD_IDX_P0_DIR, 32'hFF);
		repeat (3) @(posedge pclk);
		cmp({pin_oe[7:0], pin_o[7:0]}, 32'hFFA5);
		apb(1'b1, `GPOD_IDX_P0_DATA, 32'h5A);
		repeat (2) @(posedge pclk);
		cmp({pin_oe[7:0], pin_o[7:0]}, 32'hFF5A);
		// Port 2 all outputs, open-drain on every allowed pin
		apb(1'b1, `GPOD_IDX_P2_OD, 32'hDC);
		apb(1'b1, `GPOD_IDX_P2_DATA, 32'hA5);
		apb(1'b1, `GPOD_IDX_P2_DIR, 32'hFF);
		repeat (3) @(posedge pclk);
		cmp({pin_oe[23:16], pin_o[23:16]}, 32'h7B21);
		end_sim();
	end
endmodule : test_gpio_direction_open_drain
